// File: core/pair_load_pkg.sv
// Purpose: shared constants and types for the pair structure load decode/execute block
// Assumes: 32-bit instruction word, halfwords of a narrow encoding packed first-high
// Notes: register offsets are byte addresses on the APB slave
package pair_load_pkg;

  // ************************************************
  // instruction fields
  // ************************************************
  localparam logic [7:0] OP_TOP_WIDE = 8'hF4;
  localparam logic [7:0] OP_TOP_NARROW = 8'hF9;
  localparam logic [1:0] OP_SUB_FIXED = 2'h2;
  localparam logic [1:0] OP_SINGLE_PAIR = 2'h1;
  localparam int POS_FIX_BIT = 23;
  localparam int POS_D_BIT = 22;
  localparam int POS_BASE_LO = 16;
  localparam int POS_VD_LO = 12;
  localparam int POS_SIZE_LO = 10;
  localparam int POS_IA_LO = 4;
  localparam int POS_RSIZE_LO = 6;
  localparam int POS_T_BIT = 5;
  localparam int POS_A_BIT = 4;
  localparam int POS_OFF_LO = 0;

  // ************************************************
  // element sizes and special register numbers
  // ************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_RSV = 2'h3;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [3:0] REG_FIXED_INC = 4'hD;
  localparam logic [5:0] VREG_LAST = 6'h1F;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DECODE = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam int CTRL_EN_BIT = 0;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {
    POL_UNDEF = 2'h0,
    POL_NOP = 2'h1,
    POL_UNKNOWN = 2'h2
  } unpred_policy_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DECIDE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h3,
    ST_WBACK = 3'h4,
    ST_DONE = 3'h5
  } load_state_e;

endpackage

// File: core/decode_bus.sv
// Purpose: carries an instruction word to the decoder and its decoded fields back
// Assumes: decoder is purely combinational
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface decode_bus;
  logic [31:0] word;
  logic thumb;
  logic match;
  logic all_lanes;
  logic undef;
  logic unpred;
  logic [1:0] ebytes_log;
  logic [2:0] lane;
  logic [3:0] align;
  logic [4:0] d;
  logic [5:0] d2;
  logic [3:0] n;
  logic [3:0] m;
  logic wback;
  logic reg_index;
  modport decoder (input word, thumb, output match, all_lanes, undef, unpred, ebytes_log, lane, align,
                   d, d2, n, m, wback, reg_index);
  modport user (output word, thumb, input match, all_lanes, undef, unpred, ebytes_log, lane, align,
                d, d2, n, m, wback, reg_index);
endinterface
`default_nettype wire

// File: core/pair_decode.sv
// Purpose: field decode of the one-lane and all-lanes pair structure load
// Assumes: word is stable while the fields are used
// Notes: a one-lane word with size 11 is the all-lanes form
`timescale 1ns/10ps
`default_nettype none
module pair_decode
  import pair_load_pkg::*;
(
  // decode bundle
  decode_bus.decoder db
);
  logic [1:0] size_lane;
  logic [1:0] size_rep;
  logic [3:0] ia;
  logic inc2;
  logic [5:0] dfull;

  always_comb begin
    size_lane = db.word[POS_SIZE_LO+1:POS_SIZE_LO];
    size_rep = db.word[POS_RSIZE_LO+1:POS_RSIZE_LO];
    ia = db.word[POS_IA_LO+3:POS_IA_LO];
    db.match = (db.word[31:24] == (db.thumb ? OP_TOP_NARROW : OP_TOP_WIDE)) && db.word[POS_FIX_BIT] &&
               (db.word[21:20] == OP_SUB_FIXED) && (db.word[9:8] == OP_SINGLE_PAIR);
    db.all_lanes = (size_lane == SIZE_RSV);
    db.undef = 1'h0;
    db.lane = 3'h0;
    inc2 = 1'h0;
    db.align = 4'h1;
    db.ebytes_log = size_lane;
    if (db.all_lanes) begin
      db.ebytes_log = size_rep;
      db.undef = (size_rep == SIZE_RSV);
      inc2 = db.word[POS_T_BIT];
      if (db.word[POS_A_BIT]) begin
        db.align = 4'h2 << size_rep;
      end
    end else begin
      case (size_lane)
        SIZE_BYTE: begin
          db.lane = ia[3:1];
          db.align = ia[0] ? 4'h2 : 4'h1;
        end
        SIZE_HALF: begin
          db.lane = {1'h0, ia[3:2]};
          inc2 = ia[1];
          db.align = ia[0] ? 4'h4 : 4'h1;
        end
        default: begin
          db.undef = ia[1];
          db.lane = {2'h0, ia[3]};
          inc2 = ia[2];
          db.align = ia[0] ? 4'h8 : 4'h1;
        end
      endcase
    end
    dfull = {1'h0, db.word[POS_D_BIT], db.word[POS_VD_LO+3:POS_VD_LO]};
    db.d = dfull[4:0];
    db.d2 = dfull + (inc2 ? 6'h2 : 6'h1);
    db.n = db.word[POS_BASE_LO+3:POS_BASE_LO];
    db.m = db.word[POS_OFF_LO+3:POS_OFF_LO];
    db.wback = (db.m != REG_PC);
    db.reg_index = (db.m != REG_PC) && (db.m != REG_FIXED_INC);
    db.unpred = (db.n == REG_PC) || (db.d2 > VREG_LAST);
  end
endmodule
`default_nettype wire

// File: core/lane_pack.sv
// Purpose: places one element into a 64-bit vector register word with byte enables
// Assumes: ebytes_log is 0, 1 or 2
// Notes: unselected bytes are masked so the register file keeps them
`timescale 1ns/10ps
`default_nettype none
module lane_pack (
  // element in
  input wire logic [31:0] elem,
  input wire logic [1:0] ebytes_log,
  input wire logic [2:0] lane,
  input wire logic all_lanes,
  // register word out
  output logic [63:0] data,
  output logic [7:0] byte_en
);
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_byte
      localparam logic [2:0] BI = 3'(b);
      wire logic [1:0] sub;
      wire logic [2:0] slot;
      assign sub = (ebytes_log == 2'h0) ? 2'h0 : ((ebytes_log == 2'h1) ? {1'h0, BI[0]} : BI[1:0]);
      assign slot = (ebytes_log == 2'h0) ? BI : ((ebytes_log == 2'h1) ? {1'h0, BI[2:1]} : {2'h0, BI[2]});
      assign data[8*b+7:8*b] = elem[{sub, 3'h0} +: 8];
      assign byte_en[b] = all_lanes || (slot == lane);
    end
  endgenerate
endmodule
`default_nettype wire

// File: core/pair_load_lane_decode.sv
// Purpose: decode and execute the two-element single structure load (one lane or all lanes)
// Assumes: load unit and vector register file outside; all inputs synchronous to pclk
// Notes: one instruction in flight; registers on APB with zero wait states
`timescale 1ns/10ps
`default_nettype none
module pair_load_lane_decode
  import pair_load_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction issue
  input wire logic issue_valid,
  input wire logic [31:0] issue_word,
  input wire logic issue_thumb,
  input wire logic cond_pass,
  input wire logic simd_enable,
  input wire logic [31:0] base_value,
  input wire logic [31:0] offset_value,
  output logic issue_ready,
  // decoded fields
  output logic dec_valid,
  output logic dec_all_lanes,
  output logic [1:0] dec_ebytes_log,
  output logic [2:0] dec_lane,
  output logic [4:0] dec_d,
  output logic [5:0] dec_d2,
  output logic [3:0] dec_align,
  output logic dec_wback,
  output logic dec_reg_index,
  output logic dec_undef,
  output logic dec_unpred,
  // element reads
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // vector register writes
  output logic vrf_we,
  output logic [4:0] vrf_idx,
  output logic [63:0] vrf_data,
  output logic [7:0] vrf_be,
  // base register writeback
  output logic gpr_we,
  output logic [3:0] gpr_idx,
  output logic [31:0] gpr_data,
  // completion
  output logic done,
  output logic done_undef,
  output logic done_nop,
  output logic done_unpred,
  output logic done_align_fault
);

  // ************************************************
  // state
  // ************************************************
  load_state_e state;
  load_state_e next_state;
  logic [2:0] ctrl;
  logic [15:0] exec_count;
  logic [31:0] ins_word, base_val, off_val, elem0, elem1, ebytes;
  logic ins_thumb, ins_cond, ins_simd, rd_sel, wr_sel;
  logic f_undef, f_nop, f_align, go_read, d2_bad;
  logic [63:0] pack_data;
  logic [7:0] pack_be;
  unpred_policy_e policy;

  decode_bus db ();

  assign db.word = ins_word;
  assign db.thumb = ins_thumb;
  assign policy = unpred_policy_e'(ctrl[2:1]);

  pair_decode u_decode (
    .db(db)
  );

  lane_pack u_pack (
    .elem(wr_sel ? elem1 : elem0),
    .ebytes_log(db.ebytes_log),
    .lane(db.lane),
    .all_lanes(db.all_lanes),
    .data(pack_data),
    .byte_en(pack_be)
  );

  // ************************************************
  // execute decision
  // ************************************************
  always_comb begin
    ebytes = 32'h1 << db.ebytes_log;
    d2_bad = (db.d2 > VREG_LAST);
    f_undef = ins_cond && (!db.match || !ins_simd || db.undef || (db.n == REG_PC) ||
              (d2_bad && policy == POL_UNDEF));
    f_nop = !ins_cond || (!f_undef && d2_bad && policy == POL_NOP);
    f_align = !f_undef && !f_nop && ((base_val[3:0] & (db.align - 4'h1)) != 4'h0);
    go_read = !f_undef && !f_nop && !f_align;
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (issue_valid && issue_ready) next_state = ST_DECIDE;
      ST_DECIDE: next_state = go_read ? ST_READ : ST_DONE;
      ST_READ: if (mem_ack && rd_sel) next_state = ST_WRITE;
      ST_WRITE: if (wr_sel) next_state = ST_WBACK;
      ST_WBACK: next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      issue_ready <= 1'h0;
    end else if (ce) begin
      state <= next_state;
      issue_ready <= (next_state == ST_IDLE) && ctrl[CTRL_EN_BIT];
    end
  end

  // ************************************************
  // issue capture
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_word <= 32'h0;
      ins_thumb <= 1'h0;
      ins_cond <= 1'h0;
      ins_simd <= 1'h0;
      base_val <= 32'h0;
      off_val <= 32'h0;
    end else if (ce && state == ST_IDLE && issue_valid && issue_ready) begin
      ins_word <= issue_word;
      ins_thumb <= issue_thumb;
      ins_cond <= cond_pass;
      ins_simd <= simd_enable;
      base_val <= base_value;
      off_val <= offset_value;
    end
  end

  // ************************************************
  // decoded field presentation
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid <= 1'h0;
      dec_all_lanes <= 1'h0;
      dec_ebytes_log <= 2'h0;
      dec_lane <= 3'h0;
      dec_d <= 5'h0;
      dec_d2 <= 6'h0;
      dec_align <= 4'h1;
      dec_wback <= 1'h0;
      dec_reg_index <= 1'h0;
      dec_undef <= 1'h0;
      dec_unpred <= 1'h0;
    end else if (ce) begin
      dec_valid <= (state == ST_DECIDE);
      if (state == ST_DECIDE) begin
        dec_all_lanes <= db.all_lanes;
        dec_ebytes_log <= db.ebytes_log;
        dec_lane <= db.lane;
        dec_d <= db.d;
        dec_d2 <= db.d2;
        dec_align <= db.align;
        dec_wback <= db.wback;
        dec_reg_index <= db.reg_index;
        dec_undef <= db.undef || !db.match;
        dec_unpred <= db.unpred;
      end
    end
  end

  // ************************************************
  // element reads
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'h0;
      mem_addr <= 32'h0;
      mem_size <= 2'h0;
      rd_sel <= 1'h0;
      elem0 <= 32'h0;
      elem1 <= 32'h0;
    end else if (ce) begin
      if (state == ST_DECIDE && go_read) begin
        mem_req <= 1'h1;
        mem_addr <= base_val;
        mem_size <= db.ebytes_log;
        rd_sel <= 1'h0;
      end else if (state == ST_READ && mem_ack) begin
        if (!rd_sel) begin
          elem0 <= mem_rdata;
          rd_sel <= 1'h1;
          mem_addr <= base_val + ebytes;
        end else begin
          elem1 <= mem_rdata;
          mem_req <= 1'h0;
        end
      end
    end
  end

  // ************************************************
  // vector register writes
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_sel <= 1'h0;
      vrf_we <= 1'h0;
      vrf_idx <= 5'h0;
      vrf_data <= 64'h0;
      vrf_be <= 8'h0;
    end else if (ce) begin
      if (state == ST_WRITE) begin
        wr_sel <= 1'h1;
        vrf_we <= !wr_sel || !d2_bad;
        vrf_idx <= wr_sel ? db.d2[4:0] : db.d;
        vrf_data <= pack_data;
        vrf_be <= pack_be;
      end else begin
        wr_sel <= 1'h0;
        vrf_we <= 1'h0;
      end
    end
  end

  // ************************************************
  // base writeback and completion
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_we <= 1'h0;
      gpr_idx <= 4'h0;
      gpr_data <= 32'h0;
    end else if (ce) begin
      gpr_we <= (state == ST_WBACK) && db.wback;
      if (state == ST_WBACK) begin
        gpr_idx <= db.n;
        gpr_data <= db.reg_index ? base_val + off_val : base_val + (ebytes << 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'h0;
      done_undef <= 1'h0;
      done_nop <= 1'h0;
      done_unpred <= 1'h0;
      done_align_fault <= 1'h0;
      exec_count <= 16'h0;
    end else if (ce) begin
      done <= (state == ST_DONE);
      if (state == ST_DECIDE) begin
        done_undef <= f_undef;
        done_nop <= f_nop;
        done_unpred <= db.unpred;
        done_align_fault <= f_align;
      end
      if (state == ST_WBACK) exec_count <= exec_count + 16'h1;
    end
  end

  // ************************************************
  // apb registers
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      prdata <= 32'h0;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else if (ce) begin
      pready <= 1'h1;
      if (psel && !penable) begin
        pslverr <= !(paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_DECODE || paddr == REG_COUNT);
        case (paddr)
          REG_CTRL: prdata <= {29'h0, ctrl};
          REG_STATUS: prdata <= {27'h0, done_align_fault, done_unpred, done_nop, done_undef,
                                 (state != ST_IDLE)};
          REG_DECODE: prdata <= {7'h0, dec_unpred, dec_undef, dec_reg_index, dec_wback, dec_align,
                                 dec_d2, dec_d, dec_lane, dec_ebytes_log, dec_all_lanes};
          REG_COUNT: prdata <= {16'h0, exec_count};
          default: prdata <= 32'h0;
        endcase
      end
      if (psel && penable && pwrite && paddr == REG_CTRL) ctrl <= pwdata[2:0];
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_exec_gate:
    assert property ($rose(mem_req) |-> ins_cond && ins_simd) else $error("read issued without permission");
  a_align_gate:
    assert property ($rose(mem_req) |-> ((mem_addr[3:0] & (dec_align - 4'h1)) == 4'h0))
      else $error("read issued on misaligned base");
  a_second_addr:
    assert property (state == ST_READ && rd_sel |-> mem_addr == base_val + (32'h1 << dec_ebytes_log))
      else $error("second element address wrong");
  a_size_replicate:
    assert property (dec_valid && ins_word[11:10] == 2'h3 |-> dec_all_lanes) else $error("size 11 not replicate");
  a_replicate_undef:
    assert property (dec_valid && dec_all_lanes && ins_word[7:6] == 2'h3 |-> dec_undef)
      else $error("replicate size 11 not undefined");
  a_word_undef:
    assert property (dec_valid && !dec_all_lanes && dec_ebytes_log == 2'h2 && ins_word[5] |-> dec_undef)
      else $error("word lane bit 1 not undefined");
  a_unpred_flag:
    assert property (dec_valid && (dec_d2 > 6'h1F || ins_word[19:16] == 4'hF) |-> dec_unpred)
      else $error("unpredictable case missed");
  a_wback_sum:
    assert property (gpr_we |-> gpr_data == (dec_reg_index ? base_val + off_val : base_val + (32'h2 << dec_ebytes_log)))
      else $error("writeback value wrong");
  a_lane_mask:
    assert property (vrf_we && !dec_all_lanes |-> $countones(vrf_be) == (1 << dec_ebytes_log))
      else $error("one-lane write touches other bytes");
  a_fill_all:
    assert property (vrf_we && dec_all_lanes |-> vrf_be == 8'hFF) else $error("replicate write not full");

endmodule
`default_nettype wire

// File: tb/mem_model.sv
// Purpose: element read responder for the load unit side
// Assumes: one element request outstanding at a time
// Notes: read data outside an ack cycle changes every cycle
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // element reads
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] dly,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt;
  logic [31:0] junk;
  // ack after dly waiting cycles, one pulse per element
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      mem_ack <= 1'b0;
      junk <= 32'h0;
    end else begin
      junk <= {junk[30:0], ~junk[31]};
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack && cnt == dly) begin
        mem_ack <= 1'b1;
        cnt <= 4'h0;
      end else if (mem_req && !mem_ack) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
  assign mem_rdata = mem_ack ? (mem_addr ^ 32'h3C5A96E1) : junk;
endmodule
`default_nettype wire

// File: tb/pair_load_lane_decode_tb.sv
// Purpose: self-checking bench for the pair structure load block
// Assumes: element data follows the responder pattern
// Notes: ce is held high
`timescale 1ns/10ps
`default_nettype none
module pair_load_lane_decode_tb import pair_load_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, issue_valid = 1'b0;
  logic issue_thumb = 1'b0, cond_pass = 1'b0, simd_enable = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, issue_word = 32'h0, base_value = 32'h0, offset_value = 32'h100;
  logic [3:0] dly = 4'h0;
  logic [31:0] prdata, mem_addr, mem_rdata, gpr_data, gd, rd;
  logic pready, pslverr, issue_ready, dec_valid, dec_all_lanes, dec_wback, dec_reg_index, dec_undef, dec_unpred;
  logic [1:0] dec_ebytes_log, mem_size;
  logic [2:0] dec_lane;
  logic [4:0] dec_d, vrf_idx;
  logic [5:0] dec_d2;
  logic [3:0] dec_align, gpr_idx;
  logic mem_req, mem_ack, vrf_we, gpr_we, done, done_undef, done_nop, done_unpred, done_align_fault, er;
  logic [63:0] vrf_data;
  logic [7:0] vrf_be;
  logic [4:0] vi [2];
  logic [63:0] vd [2];
  logic [7:0] vb [2];
  int fails = 0, checks_done = 0, nv = 0, ng = 0, nd = 0, cyc = 0;
  pair_load_lane_decode pair_load_lane_decode_i (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_word, .issue_thumb, .cond_pass, .simd_enable,
    .base_value, .offset_value, .issue_ready, .dec_valid, .dec_all_lanes, .dec_ebytes_log, .dec_lane, .dec_d,
    .dec_d2, .dec_align, .dec_wback, .dec_reg_index, .dec_undef, .dec_unpred, .mem_req, .mem_addr, .mem_size,
    .mem_ack, .mem_rdata, .vrf_we, .vrf_idx, .vrf_data, .vrf_be, .gpr_we, .gpr_idx, .gpr_data, .done,
    .done_undef, .done_nop, .done_unpred, .done_align_fault);
  mem_model mem_model_i (.pclk, .presetn, .mem_req, .mem_addr, .dly, .mem_ack, .mem_rdata);
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ************************************************
  // monitor and helpers
  // ************************************************
  always @(negedge pclk) begin
    if (vrf_we === 1'b1 && nv < 2) begin
      vi[nv] = vrf_idx;
      vd[nv] = vrf_data;
      vb[nv] = vrf_be;
    end
    if (vrf_we === 1'b1) nv++;
    if (gpr_we === 1'b1) gd = gpr_data;
    if (gpr_we === 1'b1) ng++;
    if (dec_valid === 1'b1) nd++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && cyc < 20000);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // one-lane byte cases never set double spacing; the all-lanes byte case sets T, so d2 is d + 2
  function logic [31:0] ol(input logic th, input logic [1:0] sz, input logic [3:0] ia, rn, input logic [4:0] d,
    input logic [3:0] rm);
    return {th ? OP_TOP_NARROW : OP_TOP_WIDE, 1'b1, d[4], 2'b10, rn, d[3:0], sz, OP_SINGLE_PAIR, ia, rm};
  endfunction
  task run(input logic [31:0] w, input logic th, input logic [31:0] b, input logic cp, se,
    input logic [2:0] fl, input int env, eng, input logic [31:0] eg);
    nv = 0;
    ng = 0;
    nd = 0;
    while (issue_ready !== 1'b1 && cyc < 20000) @(negedge pclk);
    @(posedge pclk);
    {issue_valid, issue_word, issue_thumb, base_value, cond_pass, simd_enable} <= {1'b1, w, th, b, cp, se};
    @(posedge pclk);
    issue_valid <= 1'b0;
    do @(negedge pclk); while (done !== 1'b1 && cyc < 20000);
    chk({done_undef, done_nop, done_align_fault}, fl);
    chk(64'(nv), 64'(env));
    chk(64'(ng), 64'(eng));
    if (eng > 0) chk({gpr_idx, gd}, {w[19:16], eg});
    chk(64'(nd), 64'd1);
  endtask
  task cv(input int k, input logic [4:0] idx, input logic [31:0] a, input int eb, lane, input logic all);
    logic [31:0] e;
    logic [63:0] ed, m;
    logic [7:0] be;
    e = a ^ 32'h3C5A96E1;
    for (int i = 0; i < 8; i++) begin
      ed[i*8+:8] = e[(i%eb)*8+:8];
      be[i] = all || (i / eb == lane);
      m[i*8+:8] = {8{be[i]}};
    end
    chk(vi[k], idx);
    chk(vb[k], be);
    chk(vd[k] & m, ed & m);
  endtask
  // ************************************************
  // sequence
  // ************************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk({er, rd}, {1'b0, 32'h1});
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    run(ol(0, SIZE_BYTE, 4'hB, 4'h3, 5'd4, 4'hD), 0, 32'h1000, 1, 1, 3'b000, 2, 1, 32'h1002);
    chk({dec_ebytes_log, dec_lane, dec_d2, dec_align, dec_wback, dec_reg_index}, {2'h0, 3'h5, 6'h05, 4'h2, 2'b10});
    cv(0, 5'd4, 32'h1000, 1, 5, 0);
    cv(1, 5'd5, 32'h1001, 1, 5, 0);
    chk({dec_d, dec_undef, dec_unpred}, {5'h04, 2'b00});
    dly = 4'h3;
    run(ol(1, SIZE_HALF, 4'hF, 4'h3, 5'd4, 4'h2), 1, 32'h2004, 1, 1, 3'b000, 2, 1, 32'h2104);
    chk({dec_ebytes_log, dec_lane, dec_d2, dec_align, dec_wback, dec_reg_index}, {2'h1, 3'h3, 6'h06, 4'h4, 2'b11});
    cv(1, 5'd6, 32'h2006, 2, 3, 0);
    chk(mem_size, 2'h1);
    dly = 4'h0;
    run(ol(0, SIZE_WORD, 4'hD, 4'h3, 5'd4, 4'hF), 0, 32'h3008, 1, 1, 3'b000, 2, 0, 32'h0);
    chk({dec_ebytes_log, dec_lane, dec_d2, dec_align, dec_wback}, {2'h2, 3'h1, 6'h06, 4'h8, 1'b0});
    cv(1, 5'd6, 32'h300C, 4, 1, 0);
    run(ol(0, SIZE_WORD, 4'hD, 4'h3, 5'd4, 4'hF), 0, 32'h3004, 1, 1, 3'b001, 0, 0, 32'h0);
    run(ol(0, SIZE_WORD, 4'h2, 4'h3, 5'd4, 4'hF), 0, 32'h3008, 1, 1, 3'b100, 0, 0, 32'h0);
    for (int s = 0; s < 3; s++) begin
      run(ol(0, SIZE_RSV, {s[1:0], ~s[0], 1'b1}, 4'h3, 5'd4, 4'hD), 0, 32'h4000, 1, 1, 3'b000, 2, 1, 32'h4000 + (2 << s));
      chk({dec_all_lanes, dec_ebytes_log, dec_d2, dec_align}, {1'b1, s[1:0], 6'(s[0] ? 5 : 6), 4'(2 << s)});
      cv(0, 5'd4, 32'h4000, 1 << s, 0, 1);
      cv(1, 5'(s[0] ? 5 : 6), 32'h4000 + (1 << s), 1 << s, 0, 1);
    end
    run(ol(0, SIZE_RSV, 4'hC, 4'h3, 5'd4, 4'hF), 0, 32'h4000, 1, 1, 3'b100, 0, 0, 32'h0);
    chk(dec_undef, 1'b1);
    run(ol(0, SIZE_BYTE, 4'h0, 4'hF, 5'd4, 4'hF), 0, 32'h1000, 1, 1, 3'b100, 0, 0, 32'h0);
    chk({dec_unpred, done_unpred}, 2'b11);
    run(ol(0, SIZE_BYTE, 4'h0, 4'h3, 5'd31, 4'hD), 0, 32'h1000, 1, 1, 3'b100, 0, 0, 32'h0);
    chk({dec_unpred, dec_d2}, {1'b1, 6'd32});
    apb(1'b1, REG_CTRL, 32'h3);
    run(ol(0, SIZE_BYTE, 4'h0, 4'h3, 5'd31, 4'hD), 0, 32'h1000, 1, 1, 3'b010, 0, 0, 32'h0);
    apb(1'b1, REG_CTRL, 32'h5);
    run(ol(0, SIZE_BYTE, 4'h0, 4'h3, 5'd31, 4'hD), 0, 32'h1000, 1, 1, 3'b000, 1, 1, 32'h1002);
    cv(0, 5'd31, 32'h1000, 1, 0, 0);
    apb(1'b1, REG_CTRL, 32'h1);
    run(ol(0, SIZE_BYTE, 4'hB, 4'h3, 5'd4, 4'hD), 0, 32'h1000, 0, 1, 3'b010, 0, 0, 32'h0);
    run(ol(0, SIZE_BYTE, 4'hB, 4'h3, 5'd4, 4'hD), 0, 32'h1000, 1, 0, 3'b100, 0, 0, 32'h0);
    apb(1'b0, REG_DECODE, 32'h0);
    chk({er, rd}, {1'b0, 32'h00242928});
    apb(1'b0, REG_STATUS, 32'h0);
    chk({er, rd}, {1'b0, 32'h00000002});
    apb(1'b0, REG_COUNT, 32'h0);
    chk({er, rd}, {1'b0, 32'h00000007});
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (2) @(negedge pclk);
    chk(issue_ready, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
